// >>> io_line_config_indicators.sv
// I/O line configuration, join LED blinker and signal-strength PWM timer.
// Assumes all inputs synchronous to core_clk; registers over AXI4-Lite.
//
// Overview of operation
// - Sleep-request line codes 0,1,3,4,5: idle, wake input, input, low, high
// - Blink time sets LED on and off halves once joined, if indicator on
// - Nonzero blink time counts 10 ms; only 0 and 0x0a-0xff accepted
// - Pull-enable bit 1 connects the line's pull resistor, 0 leaves none
// - Pull-enable is 15 bits in the fixed line order, resets to 0x1fff
// - Pull-direction same order; 1 pull-up, 0 pull-down; resets 0x1fbf
// - PWM timer counts 0.1 s units, default 0x28, four seconds
// - Each received packet refreshes duty; output stops on timer expiry
// - PWM timer value 0xff keeps the output on for good
// - Supply at or below threshold appends reading and sets mask bit 7
// - Threshold in mV, 0 to 0xffff; zero suppresses the supply reading
// - Supply readout is a read-only 16-bit millivolt value
// - Firmware version is a read-only fixed four-digit hex value
// - Hardware version: upper byte device type, lower byte revision
// - Join indicator line code 1 drives the join LED, the default
//
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
`include "io_line_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module io_line_config_indicators #(
	parameter logic [15:0] FIRMWARE_VERSION = 16'h1000, // Arbitrary value
	parameter logic [7:0]  DEVICE_TYPE      = 8'h5a,    // Arbitrary value
	parameter logic [7:0]  HW_REVISION      = 8'h01,    // Arbitrary value
	parameter int          BLINK_UNIT       = `BLINK_UNIT_CYCLES,
	parameter int          PWM_UNIT         = `PWM_UNIT_CYCLES
) (
	// Clock, reset, enable
	input  wire logic                   core_clk,
	input  wire logic                   rst,
	input  wire logic                   clk_en,
	// Register bus
	input  wire io_line_pkg::axi_req_type  bus_req,
	output var  io_line_pkg::axi_resp_type bus_resp,
	// Network and sampling status
	input  wire logic                   joined,
	input  wire logic                   sleep_status,
	input  wire logic                   packet_received,
	input  wire logic [7:0]             packet_duty,
	input  wire logic [15:0]            supply_mv,
	input  wire logic                   sample_request,
	// Pins
	input  wire logic                   sleep_request_input,
	output logic                        wake_request,
	output var  io_line_pkg::line_drive_type pins,
	output logic [14:0]                 pull_enable,
	output logic [14:0]                 pull_up,
	// Sample set decoration
	output logic                        supply_append,
	output logic [7:0]                  analog_mask_extra
);
	import io_line_pkg::*;

	typedef struct packed {
		logic [7:0]  sleep_request_line_select;
		logic [7:0]  sleep_status_line_select;
		logic [7:0]  join_indicator_line_select;
		logic [7:0]  join_led_blink_time;
		logic [14:0] pull_enable_mask;
		logic [14:0] pull_direction_mask;
		logic [7:0]  signal_pwm_timer;
		logic [15:0] supply_threshold;
		logic        aw_held;
		logic [7:0]  aw_addr;
		logic        w_held;
		logic [31:0] w_data;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
		logic [31:0] blink_cnt;
		logic [7:0]  blink_units;
		logic        led;
		logic [31:0] pwm_cnt;
		logic [7:0]  pwm_units;
		logic        pwm_active;
		logic [7:0]  duty;
		logic [7:0]  phase;
		logic        pwm_level;
		logic        append;
		logic        wake;
	} state_type;

	state_type cur;
	state_type next_cur;
	function automatic logic select_ok(input logic [31:0] v);
		select_ok = (v[31:3] == 29'h0) && (v[2:0] != 3'h2)
			&& (v[2:0] <= 3'h5);
	endfunction
	function automatic logic drive_high(input logic [7:0] s);
		drive_high = (s == 8'h05);
	endfunction
	function automatic logic driving(input logic [7:0] s);
		driving = (s == 8'h04) || (s == 8'h05);
	endfunction
	logic do_write;
	logic do_read;
	logic [7:0] wa;
	logic [31:0] rd_word;
	logic rd_hit;
	assign do_write = cur.aw_held && cur.w_held && !cur.bvalid;
	assign do_read  = bus_req.arvalid && !cur.rvalid;
	assign wa = cur.aw_addr;
	always_comb begin
		rd_hit  = 1'b1;
		rd_word = 32'h0;
		unique case (bus_req.araddr)
		`SLEEP_REQUEST_LINE_SELECT_OFS:
			rd_word = {24'h0, cur.sleep_request_line_select};
		`SLEEP_STATUS_LINE_SELECT_OFS:
			rd_word = {24'h0, cur.sleep_status_line_select};
		`JOIN_INDICATOR_LINE_SELECT_OFS:
			rd_word = {24'h0, cur.join_indicator_line_select};
		`JOIN_LED_BLINK_TIME_OFS:
			rd_word = {24'h0, cur.join_led_blink_time};
		`PULL_ENABLE_MASK_OFS:
			rd_word = {17'h0, cur.pull_enable_mask};
		`PULL_DIRECTION_MASK_OFS:
			rd_word = {17'h0, cur.pull_direction_mask};
		`SIGNAL_PWM_TIMER_OFS:
			rd_word = {24'h0, cur.signal_pwm_timer};
		`SUPPLY_THRESHOLD_OFS:
			rd_word = {16'h0, cur.supply_threshold};
		`SUPPLY_VOLTAGE_OFS:
			rd_word = {16'h0, supply_mv};
		`FIRMWARE_VERSION_OFS:
			rd_word = {16'h0, FIRMWARE_VERSION};
		`HARDWARE_VERSION_OFS:
			rd_word = {16'h0, DEVICE_TYPE, HW_REVISION};
		`LINE_STATUS_OFS:
			rd_word = {28'h0, cur.append, cur.pwm_active, cur.led,
				cur.wake};
		default:
			rd_hit = 1'b0;
		endcase
	end

	always_comb begin
		logic ok;
		ok = 1'b1;
		next_cur = cur;
		// Bus: address and data taken in either order
		if (bus_req.awvalid && !cur.aw_held) begin
			next_cur.aw_held = 1'b1;
			next_cur.aw_addr = bus_req.awaddr;
		end
		if (bus_req.wvalid && !cur.w_held) begin
			next_cur.w_held = 1'b1;
			next_cur.w_data = bus_req.wdata;
		end
		if (do_write) begin
			unique case (wa)
			`SLEEP_REQUEST_LINE_SELECT_OFS: begin
				ok = select_ok(cur.w_data);
				if (ok)
					next_cur.sleep_request_line_select = cur.w_data[7:0];
			end
			`SLEEP_STATUS_LINE_SELECT_OFS: begin
				ok = select_ok(cur.w_data);
				if (ok)
					next_cur.sleep_status_line_select = cur.w_data[7:0];
			end
			`JOIN_INDICATOR_LINE_SELECT_OFS: begin
				ok = select_ok(cur.w_data);
				if (ok)
					next_cur.join_indicator_line_select = cur.w_data[7:0];
			end
			`JOIN_LED_BLINK_TIME_OFS: begin
				ok = (cur.w_data[31:8] == 24'h0) && (cur.w_data[7:0] == 8'h0
					|| cur.w_data[7:0] >= `BLINK_MIN_VALID);
				if (ok)
					next_cur.join_led_blink_time = cur.w_data[7:0];
			end
			`PULL_ENABLE_MASK_OFS:
				next_cur.pull_enable_mask = cur.w_data[14:0];
			`PULL_DIRECTION_MASK_OFS:
				next_cur.pull_direction_mask = cur.w_data[14:0];
			`SIGNAL_PWM_TIMER_OFS:
				next_cur.signal_pwm_timer = cur.w_data[7:0];
			`SUPPLY_THRESHOLD_OFS:
				next_cur.supply_threshold = cur.w_data[15:0];
			default:
				ok = 1'b0;
			endcase
			next_cur.aw_held = 1'b0;
			next_cur.w_held  = 1'b0;
			next_cur.bvalid  = 1'b1;
			next_cur.bresp   = ok ? `RESP_OKAY : `RESP_SLVERR;
		end
		if (cur.bvalid && bus_req.bready)
			next_cur.bvalid = 1'b0;
		if (do_read) begin
			next_cur.rvalid = 1'b1;
			next_cur.rdata  = rd_word;
			next_cur.rresp  = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (cur.rvalid && bus_req.rready) begin
			next_cur.rvalid = 1'b0;
		end

		if (cur.join_indicator_line_select != 8'h01 || !joined
			|| cur.join_led_blink_time == 8'h0) begin
			next_cur.led = 1'b0;
			next_cur.blink_cnt = 32'h0;
			next_cur.blink_units = 8'h0;
		end else if (cur.blink_cnt == 32'(BLINK_UNIT - 1)) begin
			next_cur.blink_cnt = 32'h0;
			// Also ends a count left over from a longer setting
			if (cur.blink_units >= cur.join_led_blink_time - 8'h1) begin
				next_cur.blink_units = 8'h0;
				next_cur.led = !cur.led;
			end else begin
				next_cur.blink_units = cur.blink_units + 8'h1;
			end
		end else begin
			next_cur.blink_cnt = cur.blink_cnt + 32'h1;
		end

		if (packet_received) begin
			next_cur.duty = packet_duty;
			next_cur.pwm_active = (cur.signal_pwm_timer != 8'h0);
			next_cur.pwm_cnt = 32'h0;
			next_cur.pwm_units = 8'h0;
		end else if (cur.pwm_active
			&& cur.signal_pwm_timer != `PWM_TIMER_FOREVER) begin
			if (cur.pwm_cnt == 32'(PWM_UNIT - 1)) begin
				next_cur.pwm_cnt = 32'h0;
				next_cur.pwm_units = cur.pwm_units + 8'h1;
				if (cur.pwm_units + 8'h1 >= cur.signal_pwm_timer)
					next_cur.pwm_active = 1'b0;
			end else begin
				next_cur.pwm_cnt = cur.pwm_cnt + 32'h1;
			end
		end
		next_cur.phase = cur.phase + 8'h1;
		next_cur.pwm_level = cur.pwm_active && (cur.phase < cur.duty);

		if (sample_request)
			next_cur.append = (cur.supply_threshold != 16'h0)
				&& (supply_mv <= cur.supply_threshold);

		next_cur.wake = (cur.sleep_request_line_select == 8'h01)
			&& sleep_request_input;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cur <= '0;
			cur.sleep_request_line_select <= `SLEEP_REQUEST_SELECT_RST;
			cur.sleep_status_line_select <= `SLEEP_STATUS_SELECT_RST;
			cur.join_indicator_line_select <= `JOIN_INDICATOR_SELECT_RST;
			cur.join_led_blink_time <= `JOIN_LED_BLINK_RST;
			cur.pull_enable_mask <= `PULL_ENABLE_RST;
			cur.pull_direction_mask <= `PULL_DIRECTION_RST;
			cur.signal_pwm_timer <= `SIGNAL_PWM_TIMER_RST;
			cur.supply_threshold <= `SUPPLY_THRESHOLD_RST;
		end else if (clk_en) begin
			cur <= next_cur;
		end
	end

	always_comb begin
		bus_resp.awready = !cur.aw_held;
		bus_resp.wready  = !cur.w_held;
		bus_resp.bvalid  = cur.bvalid;
		bus_resp.bresp   = cur.bresp;
		bus_resp.arready = !cur.rvalid;
		bus_resp.rvalid  = cur.rvalid;
		bus_resp.rdata   = cur.rdata;
		bus_resp.rresp   = cur.rresp;
	end

	always_comb begin
		pins.sleep_req_oe  = driving(cur.sleep_request_line_select);
		pins.sleep_req_out = drive_high(cur.sleep_request_line_select);
		pins.sleep_stat_oe = driving(cur.sleep_status_line_select)
			|| cur.sleep_status_line_select == 8'h01;
		pins.sleep_stat_out = (cur.sleep_status_line_select == 8'h01)
			? sleep_status : drive_high(cur.sleep_status_line_select);
		pins.join_led_oe = driving(cur.join_indicator_line_select)
			|| cur.join_indicator_line_select == 8'h01;
		pins.join_led_out = (cur.join_indicator_line_select == 8'h01)
			? cur.led : drive_high(cur.join_indicator_line_select);
		pins.pwm_out = cur.pwm_level;
	end

	assign pull_enable = cur.pull_enable_mask;
	assign pull_up = cur.pull_direction_mask & cur.pull_enable_mask;
	assign supply_append = cur.append;
	assign analog_mask_extra = {cur.append, 7'h0};
	assign wake_request = cur.wake;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);
	sequence s_write_done;
		clk_en && do_write;
	endsequence
	a_blink_write_range: assert property (
		s_write_done and (wa == `JOIN_LED_BLINK_TIME_OFS
		&& cur.w_data[7:0] inside {[8'h01:8'h09]})
		|=> bus_resp.bresp == `RESP_SLVERR && $stable(cur.join_led_blink_time))
		else $error("Blink value below range accepted");
	a_select_bad_code: assert property (
		s_write_done and (wa == `SLEEP_REQUEST_LINE_SELECT_OFS
		&& cur.w_data == 32'h2) |=> bus_resp.bresp == `RESP_SLVERR)
		else $error("Illegal sleep request code accepted");
	a_status_line_drive: assert property (
		cur.sleep_status_line_select == 8'h01
		|-> pins.sleep_stat_oe && pins.sleep_stat_out == sleep_status)
		else $error("Sleep status not driven out");
	a_led_idle_unjoined: assert property (
		!joined && clk_en |=> !cur.led)
		else $error("Join LED blinks while not joined");
	a_pwm_forever_on: assert property (
		clk_en && cur.pwm_active && !packet_received
		&& cur.signal_pwm_timer == `PWM_TIMER_FOREVER |=> cur.pwm_active)
		else $error("Permanent PWM timed out");
	a_pwm_packet_arm: assert property (
		clk_en && packet_received && cur.signal_pwm_timer != 8'h0
		|=> cur.pwm_active && cur.duty == $past(packet_duty))
		else $error("Packet did not refresh PWM");
	a_pwm_off_idle: assert property (
		clk_en && !cur.pwm_active |=> !pins.pwm_out)
		else $error("PWM output without active timer");
	a_supply_append_mask: assert property (
		clk_en && sample_request && cur.supply_threshold == 16'h0
		|=> !supply_append && analog_mask_extra == 8'h0)
		else $error("Supply appended with zero threshold");
	a_pull_up_gated: assert property (
		(pull_up & ~pull_enable) == 15'h0)
		else $error("Pull-up without pull enable");
	a_join_led_select: assert property (
		cur.join_indicator_line_select == 8'h01 |-> pins.join_led_oe
		&& pins.join_led_out == cur.led)
		else $error("Join LED not on its line");

endmodule

`default_nettype wire

// >>> io_line_config_indicators_bench.sv
// Self-checking bench for the I/O line configuration block.
// Assumes the far-side model and the register header are compiled too.
`include "io_line_regs.svh"
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin \
	n_errors++; $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); \
	end end

module io_line_config_indicators_bench;
	import io_line_pkg::*;
	logic           core_clk, rst, clk_en, joined, sleep_status, led_lit;
	logic           packet_received, sample_request, host_drive, host_level;
	logic           wake_request, supply_append, sleep_request_input, hi;
	logic [7:0]     packet_duty, analog_mask_extra, c, cq, cs, v, cb;
	logic [15:0]    supply_mv, thr;
	logic [14:0]    pull_enable, pull_up, e, d;
	logic [31:0]    seed, rd;
	logic [1:0]     rs;
	axi_req_type    req;
	axi_resp_type   resp;
	line_drive_type pins;
	int             n_errors, checks_done, i, p;
	logic [7:0]     blink_t[5] = '{8'h01, 8'h09, 8'h0a, 8'hff, 8'h00};
	logic [15:0]    thr_t[5] = '{16'h0, 16'h0ce4, 16'h0ce4, 16'h0ce4, 16'hffff};
	logic [15:0]    mv_t[5] = '{16'h0, 16'h0ce4, 16'h0ce5, 16'h0ce3, 16'hffff};

	io_line_config_indicators #(.BLINK_UNIT(4), .PWM_UNIT(8))
	io_line_config_indicators_i (.core_clk(core_clk), .rst(rst),
		.clk_en(clk_en), .bus_req(req), .bus_resp(resp), .joined(joined),
		.sleep_status(sleep_status), .packet_received(packet_received),
		.packet_duty(packet_duty), .supply_mv(supply_mv),
		.sample_request(sample_request),
		.sleep_request_input(sleep_request_input),
		.wake_request(wake_request), .pins(pins), .pull_enable(pull_enable),
		.pull_up(pull_up), .supply_append(supply_append),
		.analog_mask_extra(analog_mask_extra));

	io_line_far_side io_line_far_side_i (.core_clk(core_clk),
		.host_drive(host_drive), .host_level(host_level), .pins(pins),
		.pull_enable(pull_enable), .pull_up(pull_up),
		.sleep_request_input(sleep_request_input), .led_lit(led_lit));

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic bit sel_ok(input logic [7:0] k);
		return k inside {8'h00, 8'h01, 8'h03, 8'h04, 8'h05};
	endfunction

	function automatic logic [1:0] ok_resp(input bit ok);
		return ok ? 2'b00 : 2'b10;
	endfunction

	// Expected {drive enable, driven level} for a select code
	function automatic logic [1:0] exp_drive(input bit stat, input logic [7:0] k);
		if (k == 8'h04)
			return 2'b10;
		if (k == 8'h05)
			return 2'b11;
		if (stat && k == 8'h01)
			return {1'b1, sleep_status};
		return 2'b00;
	endfunction

	task automatic end_sim();
		if (n_errors == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] dat);
		int k;
		@(posedge core_clk);
		req.awaddr <= a;
		req.wdata <= dat;
		req.wstrb <= 4'hf;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		for (k = 0; k < 40; k++) begin
			@(posedge core_clk);
			if (req.awvalid && resp.awready)
				req.awvalid <= 1'b0;
			if (req.wvalid && resp.wready)
				req.wvalid <= 1'b0;
			if (resp.bvalid)
				break;
		end
		if (k == 40) begin
			n_errors++;
			end_sim();
		end
		rs = resp.bresp;
		req.bready <= 1'b0;
	endtask

	task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
		int k;
		@(posedge core_clk);
		req.araddr <= a;
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		for (k = 0; k < 40; k++) begin
			@(posedge core_clk);
			if (req.arvalid && resp.arready)
				req.arvalid <= 1'b0;
			if (resp.rvalid)
				break;
		end
		if (k == 40) begin
			n_errors++;
			end_sim();
		end
		rd = resp.rdata;
		rs = resp.rresp;
		req.rready <= 1'b0;
		`CHK(rd, exp)
	endtask

	task automatic pulse_packet();
		@(posedge core_clk);
		packet_received <= 1'b1;
		@(posedge core_clk);
		packet_received <= 1'b0;
	endtask

	task automatic watch(input int len);
		hi = 1'b0;
		repeat (len) begin
			@(posedge core_clk);
			hi |= pins.pwm_out;
		end
	endtask

	task automatic led_period();
		logic l;
		l = pins.join_led_out;
		for (p = 0; p < 300 && pins.join_led_out === l; p++)
			@(posedge core_clk);
		l = pins.join_led_out;
		for (p = 0; p < 300 && pins.join_led_out === l; p++)
			@(posedge core_clk);
	endtask

	initial begin
		repeat (100000) @(posedge core_clk);
		n_errors++;
		end_sim();
	end

	initial begin
		seed = 32'h000045db;
		{rst, clk_en, joined, sleep_status} = 4'b1101;
		{packet_received, sample_request, host_drive, host_level} = 4'h0;
		{packet_duty, supply_mv, req} = '0;
		{n_errors, checks_done} = '0;
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		`CHK(pins.join_led_oe, 1'b1)
		`CHK(pull_enable, 15'h1fff)
		`CHK(pull_up, 15'h1fbf)
		chk_rd(`SLEEP_STATUS_LINE_SELECT_OFS, 32'h1);
		chk_rd(`JOIN_INDICATOR_LINE_SELECT_OFS, 32'h1);
		chk_rd(`JOIN_LED_BLINK_TIME_OFS, 32'h0);
		chk_rd(`PULL_ENABLE_MASK_OFS, 32'h1fff);
		chk_rd(`PULL_DIRECTION_MASK_OFS, 32'h1fbf);
		chk_rd(`SIGNAL_PWM_TIMER_OFS, 32'h28);
		chk_rd(`SUPPLY_THRESHOLD_OFS, 32'h0);
		chk_rd(`LINE_STATUS_OFS, 32'h0);
		wr(`FIRMWARE_VERSION_OFS, 32'h0);
		`CHK(rs, `RESP_SLVERR)
		chk_rd(`FIRMWARE_VERSION_OFS, 32'h1000);
		chk_rd(`HARDWARE_VERSION_OFS, 32'h5a01);
		chk_rd(8'h30, 32'h0);
		`CHK(rs, 2'b10)
		wr(8'h34, 32'h1);
		`CHK(rs, 2'b10)
		{cq, cs} = 16'h0001;
		for (c = 0; c < 8; c++) begin
			sleep_status <= c[0];
			wr(`SLEEP_REQUEST_LINE_SELECT_OFS, {24'h0, c});
			`CHK(rs, ok_resp(sel_ok(c)))
			cq = sel_ok(c) ? c : cq;
			`CHK({pins.sleep_req_oe, pins.sleep_req_out}, exp_drive(0, cq))
			chk_rd(`SLEEP_REQUEST_LINE_SELECT_OFS, {24'h0, cq});
			wr(`SLEEP_STATUS_LINE_SELECT_OFS, {24'h0, c});
			`CHK(rs, ok_resp(sel_ok(c)))
			cs = sel_ok(c) ? c : cs;
			`CHK({pins.sleep_stat_oe, pins.sleep_stat_out}, exp_drive(1, cs))
			chk_rd(`SLEEP_STATUS_LINE_SELECT_OFS, {24'h0, cs});
		end
		wr(`SLEEP_REQUEST_LINE_SELECT_OFS, 32'h1);
		wr(`PULL_ENABLE_MASK_OFS, 32'hffffffff);
		chk_rd(`PULL_ENABLE_MASK_OFS, 32'h7fff);
		wr(`PULL_DIRECTION_MASK_OFS, 32'h7fff);
		repeat (3) @(posedge core_clk);
		`CHK(wake_request, 1'b1)
		wr(`PULL_DIRECTION_MASK_OFS, 32'h0);
		repeat (3) @(posedge core_clk);
		`CHK(wake_request, 1'b0)
		host_drive <= 1'b1;
		host_level <= 1'b1;
		repeat (3) @(posedge core_clk);
		`CHK(wake_request, 1'b1)
		clk_en <= 1'b0;
		host_level <= 1'b0;
		repeat (3) @(posedge core_clk);
		`CHK(wake_request, 1'b1)
		clk_en <= 1'b1;
		repeat (3) @(posedge core_clk);
		`CHK(wake_request, 1'b0)
		wr(`SLEEP_REQUEST_LINE_SELECT_OFS, 32'h3);
		repeat (3) @(posedge core_clk);
		`CHK(wake_request, 1'b0)
		for (i = 0; i < 4; i++) begin
			e = 15'(rnd() >> 3);
			d = 15'(rnd() >> 5);
			wr(`PULL_ENABLE_MASK_OFS, {17'h0, e});
			wr(`PULL_DIRECTION_MASK_OFS, {17'h0, d});
			`CHK(pull_enable, e)
			`CHK(pull_up, e & d)
			chk_rd(`PULL_DIRECTION_MASK_OFS, {17'h0, d});
		end
		cb = 8'h00;
		for (i = 0; i < 10; i++) begin
			v = (i < 5) ? blink_t[i] : 8'(rnd() >> 24);
			wr(`JOIN_LED_BLINK_TIME_OFS, {24'h0, v});
			`CHK(rs, ok_resp(v == 8'h00 || v >= 8'h0a))
			cb = (v == 8'h00 || v >= 8'h0a) ? v : cb;
			chk_rd(`JOIN_LED_BLINK_TIME_OFS, {24'h0, cb});
		end
		joined <= 1'b1;
		for (i = 1; i < 3; i++) begin
			wr(`JOIN_LED_BLINK_TIME_OFS, 32'h0a * i);
			led_period();
			led_period();
			`CHK(p, 40 * i)
		end
		joined <= 1'b0;
		repeat (4) @(posedge core_clk);
		`CHK(led_lit, 1'b0)
		wr(`JOIN_INDICATOR_LINE_SELECT_OFS, 32'h5);
		`CHK({pins.join_led_oe, pins.join_led_out}, 2'b11)
		wr(`JOIN_INDICATOR_LINE_SELECT_OFS, 32'h0);
		`CHK(pins.join_led_oe, 1'b0)
		wr(`JOIN_INDICATOR_LINE_SELECT_OFS, 32'h1);
		packet_duty <= 8'hff;
		wr(`SIGNAL_PWM_TIMER_OFS, 32'h2);
		pulse_packet();
		watch(12);
		`CHK(hi, 1'b1)
		repeat (20) @(posedge core_clk);
		watch(40);
		`CHK(hi, 1'b0)
		pulse_packet();
		repeat (12) @(posedge core_clk);
		pulse_packet();
		repeat (7) @(posedge core_clk);
		watch(4);
		`CHK(hi, 1'b1)
		wr(`SIGNAL_PWM_TIMER_OFS, 32'hff);
		pulse_packet();
		repeat (2100) @(posedge core_clk);
		watch(8);
		`CHK(hi, 1'b1)
		for (i = 0; i < 10; i++) begin
			thr = (i < 5) ? thr_t[i] : 16'(rnd() >> 16);
			wr(`SUPPLY_THRESHOLD_OFS, {16'h0, thr});
			supply_mv <= (i < 5) ? mv_t[i] : 16'(rnd() >> 16);
			sample_request <= 1'b1;
			@(posedge core_clk);
			sample_request <= 1'b0;
			repeat (3) @(posedge core_clk);
			hi = (thr != 16'h0) && (supply_mv <= thr);
			`CHK(supply_append, hi)
			`CHK(analog_mask_extra, {hi, 7'h0})
			chk_rd(`SUPPLY_VOLTAGE_OFS, {16'h0, supply_mv});
		end
		end_sim();
	end
endmodule

`default_nettype wire

// >>> io_line_far_side.sv
// Far-side model: host on the sleep-request pin and the join LED.
// Assumes the block's pin drives and pull controls feed it directly.
`timescale 1ns/100ps
`default_nettype none

module io_line_far_side (
	// Clock and host control
	input  wire logic                        core_clk,
	input  wire logic                        host_drive,
	input  wire logic                        host_level,
	// Block side
	input  wire io_line_pkg::line_drive_type pins,
	input  wire logic [14:0]                 pull_enable,
	input  wire logic [14:0]                 pull_up,
	output logic                             sleep_request_input,
	output logic                             led_lit
);
	import io_line_pkg::*;
	logic float_level = 1'b0;

	// Floating line wanders, so a stale level never passes for a pull
	always_ff @(posedge core_clk) begin
		float_level <= ~float_level;
	end

	always_comb begin
		if (pins.sleep_req_oe)
			sleep_request_input = pins.sleep_req_out;
		else if (host_drive)
			sleep_request_input = host_level;
		else if (pull_enable[6])
			sleep_request_input = pull_up[6];
		else
			sleep_request_input = float_level;
	end

	assign led_lit = pins.join_led_oe & pins.join_led_out;
endmodule

`default_nettype wire

// >>> io_line_pkg.sv
// Types shared by the I/O line configuration block.
// Assumes the register header is included by the design file.
package io_line_pkg;

	typedef enum logic [2:0] {
		sel_unmonitored = 3'h0,
		sel_special     = 3'h1,
		sel_digital_in  = 3'h3,
		sel_drive_low   = 3'h4,
		sel_drive_high  = 3'h5
	} line_select_type;

	typedef struct packed {
		logic [7:0] awaddr;
		logic       awvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic       wvalid;
		logic       bready;
		logic [7:0] araddr;
		logic       arvalid;
		logic       rready;
	} axi_req_type;

	typedef struct packed {
		logic       awready;
		logic       wready;
		logic [1:0] bresp;
		logic       bvalid;
		logic       arready;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic       rvalid;
	} axi_resp_type;

	typedef struct packed {
		logic sleep_req_out;
		logic sleep_req_oe;
		logic sleep_stat_out;
		logic sleep_stat_oe;
		logic join_led_out;
		logic join_led_oe;
		logic pwm_out;
	} line_drive_type;

endpackage

// >>> io_line_regs.svh
// Register map and timing constants for the I/O line configuration block.
// Assumes a 100 MHz core clock and a 32-bit AXI4-Lite register port.
`ifndef IO_LINE_REGS_SVH
`define IO_LINE_REGS_SVH

`define SLEEP_REQUEST_LINE_SELECT_OFS	8'h00
`define SLEEP_STATUS_LINE_SELECT_OFS	8'h04
`define JOIN_INDICATOR_LINE_SELECT_OFS	8'h08
`define JOIN_LED_BLINK_TIME_OFS		8'h0c
`define PULL_ENABLE_MASK_OFS		8'h10
`define PULL_DIRECTION_MASK_OFS		8'h14
`define SIGNAL_PWM_TIMER_OFS		8'h18
`define SUPPLY_THRESHOLD_OFS		8'h1c
`define SUPPLY_VOLTAGE_OFS		8'h20
`define FIRMWARE_VERSION_OFS		8'h24
`define HARDWARE_VERSION_OFS		8'h28
`define LINE_STATUS_OFS			8'h2c

`define SLEEP_REQUEST_SELECT_RST	8'h00
`define SLEEP_STATUS_SELECT_RST		8'h01
`define JOIN_INDICATOR_SELECT_RST	8'h01
`define JOIN_LED_BLINK_RST		8'h00
`define PULL_ENABLE_RST			15'h1fff
`define PULL_DIRECTION_RST		15'h1fbf
`define SIGNAL_PWM_TIMER_RST		8'h28
`define SUPPLY_THRESHOLD_RST		16'h0000

`define PWM_TIMER_FOREVER		8'hff
`define BLINK_MIN_VALID			8'h0a
`define SUPPLY_MASK_BIT			7

`define CLOCK_HZ			100000000
`define BLINK_UNIT_MS			10
`define PWM_UNIT_MS			100
`define BLINK_UNIT_CYCLES	(`CLOCK_HZ / 1000 * `BLINK_UNIT_MS)
`define PWM_UNIT_CYCLES		(`CLOCK_HZ / 1000 * `PWM_UNIT_MS)

`define RESP_OKAY			2'b00
`define RESP_SLVERR			2'b10

`endif
